//--- src/fqr_pkg.sv
// package for the feature query responder: ranges, leaf codes, request and answer carriers
package fqr_pkg;

	localparam logic [31:0] STD_BASE      = 32'h0000_0000;
	localparam logic [31:0] STD_LAST      = 32'h0000_ffff;
	localparam logic [31:0] EXT_BASE      = 32'h8000_0000;
	localparam logic [31:0] EXT_LAST      = 32'h8000_ffff;
	localparam logic [15:0] LEAF_VENDOR   = 16'h0000;
	localparam logic [15:0] LEAF_FEATURE  = 16'h0001;
	localparam logic [15:0] LEAF_CACHE    = 16'h0004;
	localparam logic [15:0] LEAF_NAME0    = 16'h0002;
	localparam logic [15:0] LEAF_NAME2    = 16'h0004;
	localparam logic [31:0] CACHE_SUBS    = 32'h0000_0003;
	localparam logic [7:0]  FLAG_LONG_BIT = 8'h1d;

	typedef struct packed {
		logic [31:0] first_general_register;
		logic [31:0] third_general_register;
	} fqr_req_t;

	typedef struct packed {
		logic [31:0] first_general_register;
		logic [31:0] second_general_register;
		logic [31:0] third_general_register;
		logic [31:0] fourth_general_register;
	} fqr_ans_t;

	typedef enum logic [1:0] {
		FQR_CLS_STD  = 2'b00,
		FQR_CLS_EXT  = 2'b01,
		FQR_CLS_NONE = 2'b10
	} fqr_cls_t;

	typedef enum logic [0:0] {
		FQR_IDLE = 1'b0,
		FQR_DONE = 1'b1
	} fqr_state_t;

endpackage : fqr_pkg

//--- src/fqr_table.sv
// combinational capability lookup, keyed on function number and sub-selector
`timescale 1ns/100ps
module fqr_table #(
	parameter logic [31:0] STD_MAX   = 32'h0000_0004,
	parameter logic [31:0] EXT_MAX   = 32'h8000_0004,
	parameter logic [31:0] VENDOR0   = 32'h6c61_6e69, // arbitrary vendor text
	parameter logic [31:0] VENDOR1   = 32'h6b61_6d65,
	parameter logic [31:0] VENDOR2   = 32'h6f72_6765,
	parameter logic [31:0] SIGNATURE = 32'h0000_0a11, // arbitrary model and stepping
	parameter logic [31:0] STD_FLAGS = 32'h0000_0211,
	parameter logic [31:0] EXT_FLAGS = 32'h2000_0000
) (
	// query
	input  wire fqr_pkg::fqr_req_t req_i,
	// answer
	output fqr_pkg::fqr_ans_t      ans_o
);

	function automatic fqr_pkg::fqr_cls_t classify(input logic [31:0] fn);
		if (fn <= fqr_pkg::STD_LAST)
			return fqr_pkg::FQR_CLS_STD;
		else if (fn >= fqr_pkg::EXT_BASE && fn <= fqr_pkg::EXT_LAST)
			return fqr_pkg::FQR_CLS_EXT;
		else
			return fqr_pkg::FQR_CLS_NONE;
	endfunction : classify

	function automatic logic [31:0] name_word(input logic [3:0] idx);
		// name string bytes, little end first; text is arbitrary
		return {4{4'h4, idx}};
	endfunction : name_word

	logic [31:0] fn;
	logic [31:0] sub;
	logic [15:0] leaf;
	logic [31:0] ext_flags;

	assign fn   = req_i.first_general_register;
	assign sub  = req_i.third_general_register;
	assign leaf = fn[15:0];

	// long mode flag held as one bit: 1 means supported
	// this core always runs long mode, so the bit is forced whatever the parameter says
	always_comb
	begin
		ext_flags = EXT_FLAGS;
		ext_flags[fqr_pkg::FLAG_LONG_BIT[4:0]] = 1'b1;
	end

	// pure function of the inputs, so repeat queries always agree
	always_comb
	begin
		ans_o = '0;
		case (classify(fn))
			fqr_pkg::FQR_CLS_STD:
			begin
				if (fn <= STD_MAX)
				begin
					case (leaf)
						fqr_pkg::LEAF_VENDOR:
							ans_o = {STD_MAX, VENDOR0, VENDOR2, VENDOR1};
						fqr_pkg::LEAF_FEATURE:
							ans_o = {SIGNATURE, 32'h0000_0000, 32'h0000_0000, STD_FLAGS};
						fqr_pkg::LEAF_CACHE:
						begin
							// only this leaf reads the sub-selector; others ignore it
							if (sub <= fqr_pkg::CACHE_SUBS)
								ans_o = {sub + 32'h0000_0001, 32'h0000_003f,
									32'h0000_00ff, 32'h0000_0000};
						end
						default:
							ans_o = '0;
					endcase
				end
			end
			fqr_pkg::FQR_CLS_EXT:
			begin
				if (fn <= EXT_MAX)
				begin
					case (leaf)
						fqr_pkg::LEAF_VENDOR:
							ans_o = {EXT_MAX, VENDOR0, VENDOR2, VENDOR1};
						fqr_pkg::LEAF_FEATURE:
							ans_o = {SIGNATURE, 32'h0000_0000, 32'h0000_0000, ext_flags};
						default:
						begin
							if (leaf >= fqr_pkg::LEAF_NAME0 && leaf <= fqr_pkg::LEAF_NAME2)
								ans_o = {4{name_word(leaf[3:0])}};
						end
					endcase
				end
			end
			default:
				ans_o = '0;
		endcase
	end

endmodule : fqr_table

//--- src/fqr_top.sv
// feature query responder: registers the lookup answer for the core
`timescale 1ns/100ps
// Functional notes
// - query runs at every privilege level; no fault is ever raised
// - full 32-bit first register value selects the function
// - functions 0000_0000h to 0000_ffffh are standard functions
// - functions 8000_0000h to 8000_ffffh are extended functions
// - answer fills all four general registers
// - third register is a sub-selector only where the function takes one
// - each feature flag bit is 1 when supported, 0 when not
// - functions give vendor, model, stepping, features, cache and name
module fqr_top (
	// clock and reset
	input  wire                    clk_sys_i,
	input  wire                    rst_i,
	input  wire                    clk_en_i,
	// query from core
	input  wire                    query_valid_i,
	input  wire [1:0]              priv_level_i,
	input  wire fqr_pkg::fqr_req_t query_i,
	// answer to core
	output logic                   answer_valid_o,
	output fqr_pkg::fqr_ans_t      answer_o,
	output logic                   fault_o
);

	fqr_pkg::fqr_ans_t   table_ans;
	fqr_pkg::fqr_ans_t   next_answer;
	fqr_pkg::fqr_state_t state;
	fqr_pkg::fqr_state_t next_state;
	logic                next_valid;
	logic [1:0]          unused_priv;

	fqr_table u_table (
		.req_i (query_i),
		.ans_o (table_ans)
	);

	// privilege level is deliberately not examined
	assign unused_priv = priv_level_i;
	assign fault_o     = 1'b0;

	always_comb
	begin
		next_state  = state;
		next_valid  = 1'b0;
		next_answer = answer_o;
		case (state)
			fqr_pkg::FQR_IDLE:
			begin
				if (query_valid_i)
				begin
					next_answer = table_ans;
					next_valid  = 1'b1;
					next_state  = fqr_pkg::FQR_DONE;
				end
			end
			fqr_pkg::FQR_DONE:
			begin
				// back to back queries allowed
				if (query_valid_i)
				begin
					next_answer = table_ans;
					next_valid  = 1'b1;
				end
				else
					next_state = fqr_pkg::FQR_IDLE;
			end
			default:
				next_state = fqr_pkg::FQR_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state          <= fqr_pkg::FQR_IDLE;
			answer_valid_o <= 1'b0;
			answer_o       <= '0;
		end
		else if (clk_en_i)
		begin
			state          <= next_state;
			answer_valid_o <= next_valid;
			answer_o       <= next_answer;
		end
	end

endmodule : fqr_top

//--- sim/fqr_chk.sv
// port checker for the feature query responder
`timescale 1ns/100ps
module fqr_chk (
	// clock and reset
	input wire                    clk_sys_i,
	input wire                    rst_i,
	input wire                    clk_en_i,
	// query side
	input wire                    query_valid_i,
	input wire [1:0]              priv_level_i,
	input wire fqr_pkg::fqr_req_t query_i,
	// answer side
	input wire                    answer_valid_o,
	input wire fqr_pkg::fqr_ans_t answer_o,
	input wire                    fault_o
);
	wire tk = clk_en_i && query_valid_i;
	wire [31:0] f = query_i.first_general_register;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	property p_nf; fault_o == 1'b0; endproperty
	a_nf: assert property (p_nf) else $error("fault raised");
	property p_v; tk |=> answer_valid_o; endproperty
	a_v: assert property (p_v) else $error("no answer");
	property p_nv; clk_en_i && !tk |=> !answer_valid_o; endproperty
	a_nv: assert property (p_nv) else $error("stray answer");
	property p_h; clk_en_i && !tk |=> $stable(answer_o); endproperty
	a_h: assert property (p_h) else $error("answer moved");
	property p_gap; tk && f > 32'h0000_0004 && f < 32'h8000_0000 |=> answer_o == '0; endproperty
	a_gap: assert property (p_gap) else $error("gap not zero");
	property p_ex; tk && f > 32'h8000_0004 |=> answer_o == '0; endproperty
	a_ex: assert property (p_ex) else $error("ext not zero");
	property p_lm; tk && f == 32'h8000_0001 |=> answer_o.fourth_general_register[29]; endproperty
	a_lm: assert property (p_lm) else $error("long flag");
	property p_sub; tk && f == 32'h4 && query_i.third_general_register > 32'h3 |=> answer_o == '0;
	endproperty
	a_sub: assert property (p_sub) else $error("sub not zero");
endmodule : fqr_chk
bind fqr_top fqr_chk u_fqr_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
	.query_valid_i(query_valid_i), .answer_valid_o(answer_valid_o), .fault_o(fault_o),
	.priv_level_i(priv_level_i), .query_i(query_i), .answer_o(answer_o));

//--- sim/tb_fqr_top.sv
// self-checking bench for the feature query responder
`timescale 1ns/100ps
module tb_fqr_top;
	logic clk_sys_i = 0, rst_i = 1, clk_en_i = 1, query_valid_i = 0;
	logic [1:0] priv_level_i = 0;
	fqr_pkg::fqr_req_t query_i = '0;
	fqr_pkg::fqr_ans_t answer_o, a;
	logic answer_valid_o, fault_o;
	int fail_count = 0, n_checks = 0, cyc = 0;
	fqr_top u_fqr_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
		.query_valid_i(query_valid_i), .priv_level_i(priv_level_i), .query_i(query_i),
		.answer_valid_o(answer_valid_o), .answer_o(answer_o), .fault_o(fault_o));
	initial forever #5 clk_sys_i = ~clk_sys_i;
	task chk(input logic [127:0] s, e, input string w);
		n_checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("wrong value %s exp %h seen %h", w, e, s);
		end
	endtask : chk
	task ask(input logic [31:0] f, s);
		query_valid_i = 1;
		query_i = '{f, s};
		@(negedge clk_sys_i);
		query_valid_i = 0;
		chk(answer_valid_o, 1, "valid");
		a = answer_o;
		// let an idle edge pass so the next request never reraises valid in this step
		@(negedge clk_sys_i);
		chk(answer_valid_o, 0, "pulse");
		chk(answer_o, a, "stands");
	endtask : ask
	task t_vendor;
		for (int p = 0; p < 4; p++)
		begin
			priv_level_i = 2'(p);
			ask(0, p);
			chk(a, {32'h4, 32'h6c61_6e69, 32'h6f72_6765, 32'h6b61_6d65}, "vendor");
			chk(fault_o, 0, "fault");
		end
		ask(1, 0);
		chk(a, {32'h0a11, 64'h0, 32'h0211}, "features");
		ask(32'h8000_0001, 0);
		chk(a.fourth_general_register[29], 1, "long");
		chk(a, {32'h0a11, 64'h0, 32'h2000_0000}, "ext features");
		ask(32'h8000_0000, 0);
		chk(a, {32'h8000_0004, 32'h6c61_6e69, 32'h6f72_6765, 32'h6b61_6d65},
			"ext vendor");
		$display("vendor done");
	endtask : t_vendor
	task t_cache;
		for (int s = 0; s < 5; s++)
		begin
			ask(4, s);
			chk(a, s < 4 ? {s + 1, 32'h3f, 32'hff, 32'h0} : 128'h0, "cache");
		end
		$display("cache done");
	endtask : t_cache
	task t_range;
		logic [31:0] f [6] = '{32'h0001_0000, 32'h7fff_ffff, 32'h8001_0000,
			32'h0000_0005, 32'h8000_0005, 32'hffff_ffff};
		for (int i = 2; i < 5; i++)
		begin
			ask(32'h8000_0000 + i, 0);
			chk(a, {16{4'h4, 4'(i)}}, "name");
		end
		foreach (f[i])
		begin
			ask(f[i], 0);
			chk(a, 0, "range");
		end
		$display("range done");
	endtask : t_range
	task t_hold;
		ask(1, 0);
		clk_en_i = 0;
		query_valid_i = 1;
		query_i = '0;
		repeat (2) @(negedge clk_sys_i);
		chk(answer_o, {32'h0a11, 64'h0, 32'h0211}, "frozen");
		clk_en_i = 1;
		query_valid_i = 0;
		@(negedge clk_sys_i);
		chk(answer_valid_o, 0, "idle");
		$display("hold done");
	endtask : t_hold
	task t_burst;
		query_valid_i = 1;
		query_i = '{32'h0, 32'h0};
		@(negedge clk_sys_i);
		query_i = '{32'h1, 32'h0};
		chk(answer_o, {32'h4, 32'h6c61_6e69, 32'h6f72_6765, 32'h6b61_6d65}, "burst 1");
		@(negedge clk_sys_i);
		query_valid_i = 0;
		chk(answer_valid_o, 1, "burst valid");
		chk(answer_o, {32'h0a11, 64'h0, 32'h0211}, "burst 2");
		@(negedge clk_sys_i);
		chk(answer_valid_o, 0, "burst end");
		$display("burst done");
	endtask : t_burst
	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc > 2000)
		begin
			fail_count++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (10) @(negedge clk_sys_i);
		rst_i = 0;
		t_vendor();
		t_cache();
		t_range();
		t_hold();
		t_burst();
		give_verdict();
	end
endmodule : tb_fqr_top
